/* File: pkg/nifm_params.svh */
// constants for the network input function map
`ifndef NIFM_PARAMS_SVH
`define NIFM_PARAMS_SVH
`define NIFM_NUM_BITS      16
`define NIFM_CODE_W        7
`define NIFM_NUM_FUNCS     128
`define NIFM_CODE_UNUSED   7'h00
`define NIFM_CODE_FORWARD  7'h01
`define NIFM_CODE_REVERSE  7'h02
`define NIFM_CODE_HOMING   7'h03
`define NIFM_CODE_SEQSTART 7'h05
`define NIFM_CODE_ALMCLR   7'h18
`define NIFM_CODE_INTLK    7'h1b
`define NIFM_CODE_FLAG0    7'h20
`define NIFM_CODE_FLAG15   7'h2f
`define NIFM_CODE_DSEL0    7'h30
`define NIFM_CODE_RST      7'h00
`endif

/* File: pkg/nifm_pkg.sv */
// types for the network input function map
package nifm_pkg;
    `include "nifm_params.svh"
    typedef logic [`NIFM_CODE_W-1:0]    nifm_code_t;
    typedef logic [`NIFM_NUM_FUNCS-1:0] nifm_func_vec_t;
    typedef struct packed {
        logic [`NIFM_NUM_BITS-1:0]  net_sync1;
        logic [`NIFM_NUM_BITS-1:0]  net_sync2;
        logic [`NIFM_NUM_FUNCS-1:0] direct_sync1;
        logic [`NIFM_NUM_FUNCS-1:0] direct_sync2;
        logic [`NIFM_NUM_FUNCS-1:0] func;
    } nifm_state_t;
endpackage

/* File: hdl/nifm_top.sv */
// network input function map: routes network input bits to input functions
`timescale 1ns/100ps
`include "nifm_params.svh"
module nifm_top (
    input  wire logic                      clk_i,
    input  wire logic                      arst_n_i,
    input  wire logic [15:0]               network_input_bit_i,
    input  wire nifm_pkg::nifm_code_t      net_code_i [16],
    input  wire logic [127:0]              direct_active_i,
    input  wire logic [127:0]              direct_assigned_i,
    output logic [127:0]                   func_o,
    output logic                           operator_interlock_o,
    output logic                           alarm_clear_input_o,
    output logic                           sequential_start_input_o,
    output logic                           forward_run_input_o,
    output logic                           reverse_run_input_o,
    output logic                           data_select_bit_0_o,
    output logic [15:0]                    general_host_flag_o
);
    import nifm_pkg::*;

    nifm_state_t state_q;
    nifm_state_t state_d;

    // ----------------------------------------
    // code decode
    // ----------------------------------------
    function automatic nifm_func_vec_t decode_code(input nifm_code_t code);
        nifm_func_vec_t v;
        v = '0;
        if (code != `NIFM_CODE_UNUSED) begin
            v[code] = 1'b1;
        end
        return v;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nifm_func_vec_t net_on;
        nifm_func_vec_t net_sel;
        nifm_func_vec_t dir_sel;
        nifm_func_vec_t dir_on;
        net_on  = '0;
        net_sel = '0;
        dir_sel = '0;
        dir_on  = '0;
        state_d = state_q;
        state_d.net_sync1    = network_input_bit_i;
        state_d.net_sync2    = state_q.net_sync1;
        state_d.direct_sync1 = direct_active_i;
        state_d.direct_sync2 = state_q.direct_sync1;
        for (int i = 0; i < `NIFM_NUM_BITS; i++) begin
            net_sel = net_sel | decode_code(net_code_i[i]);
            if (state_q.net_sync2[i]) begin
                net_on = net_on | decode_code(net_code_i[i]);
            end
        end
        dir_sel = direct_assigned_i;
        dir_on  = state_q.direct_sync2 & dir_sel;
        for (int f = 0; f < `NIFM_NUM_FUNCS; f++) begin
            if (net_sel[f] && dir_sel[f]) begin
                state_d.func[f] = net_on[f] & dir_on[f];
            end else begin
                state_d.func[f] = net_on[f] | dir_on[f];
            end
        end
        if (!net_sel[`NIFM_CODE_INTLK] && !dir_sel[`NIFM_CODE_INTLK]) begin
            state_d.func[`NIFM_CODE_INTLK] = 1'b1;
        end
        state_d.func[`NIFM_CODE_UNUSED] = 1'b0;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign func_o                   = state_q.func;
    assign operator_interlock_o     = state_q.func[`NIFM_CODE_INTLK];
    assign alarm_clear_input_o      = state_q.func[`NIFM_CODE_ALMCLR];
    assign sequential_start_input_o = state_q.func[`NIFM_CODE_SEQSTART];
    assign forward_run_input_o      = state_q.func[`NIFM_CODE_FORWARD];
    assign reverse_run_input_o      = state_q.func[`NIFM_CODE_REVERSE];
    assign data_select_bit_0_o      = state_q.func[`NIFM_CODE_DSEL0];
    assign general_host_flag_o      = state_q.func[`NIFM_CODE_FLAG15:`NIFM_CODE_FLAG0];

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    unused_never_a: assert property (func_o[0] == 1'b0)
        else $error("unused function code active");

    net_or_a: assert property (
        (net_code_i[0] == `NIFM_CODE_FLAG0 && !direct_assigned_i[32] && $stable(net_code_i[0])
         && state_q.net_sync2[0]) |=> general_host_flag_o[0])
        else $error("network bit did not raise its function");

    intlk_default_a: assert property (
        (direct_assigned_i[27] == 1'b0 && net_code_i[0] != `NIFM_CODE_INTLK
         && net_code_i[1] != `NIFM_CODE_INTLK && net_code_i[2] != `NIFM_CODE_INTLK
         && net_code_i[3] != `NIFM_CODE_INTLK && net_code_i[4] != `NIFM_CODE_INTLK
         && net_code_i[5] != `NIFM_CODE_INTLK && net_code_i[6] != `NIFM_CODE_INTLK
         && net_code_i[7] != `NIFM_CODE_INTLK && net_code_i[8] != `NIFM_CODE_INTLK
         && net_code_i[9] != `NIFM_CODE_INTLK && net_code_i[10] != `NIFM_CODE_INTLK
         && net_code_i[11] != `NIFM_CODE_INTLK && net_code_i[12] != `NIFM_CODE_INTLK
         && net_code_i[13] != `NIFM_CODE_INTLK && net_code_i[14] != `NIFM_CODE_INTLK
         && net_code_i[15] != `NIFM_CODE_INTLK) |=> operator_interlock_o)
        else $error("interlock not held on");

    and_block_a: assert property (
        (net_code_i[0] == `NIFM_CODE_FORWARD && direct_assigned_i[1]
         && !state_q.direct_sync2[1]) |=> !forward_run_input_o)
        else $error("direct off did not block network source");

    direct_or_a: assert property (
        (direct_assigned_i[47] && state_q.direct_sync2[47] && net_code_i[0] != 7'h2f
         && net_code_i[1] != 7'h2f && net_code_i[2] != 7'h2f && net_code_i[3] != 7'h2f
         && net_code_i[4] != 7'h2f && net_code_i[5] != 7'h2f && net_code_i[6] != 7'h2f
         && net_code_i[7] != 7'h2f && net_code_i[8] != 7'h2f && net_code_i[9] != 7'h2f
         && net_code_i[10] != 7'h2f && net_code_i[11] != 7'h2f && net_code_i[12] != 7'h2f
         && net_code_i[13] != 7'h2f && net_code_i[14] != 7'h2f && net_code_i[15] != 7'h2f)
        |=> general_host_flag_o[15])
        else $error("direct-only flag not passed");

    sync_lat_a: assert property (
        ($rose(network_input_bit_i[3]) && net_code_i[3] == `NIFM_CODE_SEQSTART
         && !direct_assigned_i[5])
        ##1 (network_input_bit_i[3] && $stable(net_code_i[3]))[*2]
        |=> sequential_start_input_o)
        else $error("network bit latency wrong");

    and_pass_a: assert property (
        (net_code_i[0] == `NIFM_CODE_FORWARD && state_q.net_sync2[0] && direct_assigned_i[1]
         && state_q.direct_sync2[1]) |=> forward_run_input_o)
        else $error("both sources on but function off");

    fwd_or_a: assert property (
        (net_code_i[9] == `NIFM_CODE_FORWARD && state_q.net_sync2[9] && !direct_assigned_i[1])
        |=> forward_run_input_o)
        else $error("second network bit did not raise its function");

    rev_and_a: assert property (
        (net_code_i[4] == `NIFM_CODE_REVERSE && state_q.net_sync2[4] && direct_assigned_i[2]
         && state_q.direct_sync2[2]) |=> reverse_run_input_o)
        else $error("reverse run off with both sources on");

    dsel_route_a: assert property (
        (net_code_i[8] == `NIFM_CODE_DSEL0 && state_q.net_sync2[8] && !direct_assigned_i[48])
        |=> data_select_bit_0_o)
        else $error("network bit did not reach its data select");

    alarm_direct_a: assert property (
        (direct_assigned_i[24] && state_q.direct_sync2[24]
         && net_code_i[0] != `NIFM_CODE_ALMCLR && net_code_i[1] != `NIFM_CODE_ALMCLR
         && net_code_i[2] != `NIFM_CODE_ALMCLR && net_code_i[3] != `NIFM_CODE_ALMCLR
         && net_code_i[4] != `NIFM_CODE_ALMCLR && net_code_i[5] != `NIFM_CODE_ALMCLR
         && net_code_i[6] != `NIFM_CODE_ALMCLR && net_code_i[7] != `NIFM_CODE_ALMCLR
         && net_code_i[8] != `NIFM_CODE_ALMCLR && net_code_i[9] != `NIFM_CODE_ALMCLR
         && net_code_i[10] != `NIFM_CODE_ALMCLR && net_code_i[11] != `NIFM_CODE_ALMCLR
         && net_code_i[12] != `NIFM_CODE_ALMCLR && net_code_i[13] != `NIFM_CODE_ALMCLR
         && net_code_i[14] != `NIFM_CODE_ALMCLR && net_code_i[15] != `NIFM_CODE_ALMCLR)
        |=> alarm_clear_input_o)
        else $error("direct-only alarm clear not passed");

    intlk_off_a: assert property (
        (net_code_i[6] == `NIFM_CODE_INTLK && !state_q.net_sync2[6] && !direct_assigned_i[27]
         && net_code_i[0] != `NIFM_CODE_INTLK && net_code_i[1] != `NIFM_CODE_INTLK
         && net_code_i[2] != `NIFM_CODE_INTLK && net_code_i[3] != `NIFM_CODE_INTLK
         && net_code_i[4] != `NIFM_CODE_INTLK && net_code_i[5] != `NIFM_CODE_INTLK
         && net_code_i[7] != `NIFM_CODE_INTLK && net_code_i[8] != `NIFM_CODE_INTLK
         && net_code_i[9] != `NIFM_CODE_INTLK && net_code_i[10] != `NIFM_CODE_INTLK
         && net_code_i[11] != `NIFM_CODE_INTLK && net_code_i[12] != `NIFM_CODE_INTLK
         && net_code_i[13] != `NIFM_CODE_INTLK && net_code_i[14] != `NIFM_CODE_INTLK
         && net_code_i[15] != `NIFM_CODE_INTLK) |=> !operator_interlock_o)
        else $error("interlock on with its only terminal off");

    flag_follow_a: assert property (
        (net_code_i[15] == `NIFM_CODE_FLAG15 && !state_q.net_sync2[15]
         && !direct_assigned_i[47] && net_code_i[0] != `NIFM_CODE_FLAG15
         && net_code_i[1] != `NIFM_CODE_FLAG15 && net_code_i[2] != `NIFM_CODE_FLAG15
         && net_code_i[3] != `NIFM_CODE_FLAG15 && net_code_i[4] != `NIFM_CODE_FLAG15
         && net_code_i[5] != `NIFM_CODE_FLAG15 && net_code_i[6] != `NIFM_CODE_FLAG15
         && net_code_i[7] != `NIFM_CODE_FLAG15 && net_code_i[8] != `NIFM_CODE_FLAG15
         && net_code_i[9] != `NIFM_CODE_FLAG15 && net_code_i[10] != `NIFM_CODE_FLAG15
         && net_code_i[11] != `NIFM_CODE_FLAG15 && net_code_i[12] != `NIFM_CODE_FLAG15
         && net_code_i[13] != `NIFM_CODE_FLAG15 && net_code_i[14] != `NIFM_CODE_FLAG15)
        |=> !general_host_flag_o[15])
        else $error("host flag on with its network bit off");

    homing_idle_a: assert property (
        (!direct_assigned_i[3]
         && net_code_i[0] != `NIFM_CODE_HOMING && net_code_i[1] != `NIFM_CODE_HOMING
         && net_code_i[2] != `NIFM_CODE_HOMING && net_code_i[3] != `NIFM_CODE_HOMING
         && net_code_i[4] != `NIFM_CODE_HOMING && net_code_i[5] != `NIFM_CODE_HOMING
         && net_code_i[6] != `NIFM_CODE_HOMING && net_code_i[7] != `NIFM_CODE_HOMING
         && net_code_i[8] != `NIFM_CODE_HOMING && net_code_i[9] != `NIFM_CODE_HOMING
         && net_code_i[10] != `NIFM_CODE_HOMING && net_code_i[11] != `NIFM_CODE_HOMING
         && net_code_i[12] != `NIFM_CODE_HOMING && net_code_i[13] != `NIFM_CODE_HOMING
         && net_code_i[14] != `NIFM_CODE_HOMING && net_code_i[15] != `NIFM_CODE_HOMING)
        |=> !func_o[3])
        else $error("unselected function became active");

    // ----------------------------------------
    // cover properties
    // ----------------------------------------
    net_flag_c:  cover property (general_host_flag_o[0]);
    intlk_off_c: cover property (!operator_interlock_o);
    and_both_c:  cover property (forward_run_input_o && direct_assigned_i[1]);
    alarm_c:     cover property (alarm_clear_input_o);
    seq_start_c: cover property (sequential_start_input_o);
endmodule // nifm_top

/* File: bench/nifm_host_model.sv */
// host model: holds network input bits and their function codes
`timescale 1ns/100ps
module nifm_host_model (
    output logic [15:0]          network_input_bit_o,
    output nifm_pkg::nifm_code_t net_code_o [16]
);
    import nifm_pkg::*;
    // one code may go to several bits, not refused
    task automatic set_bit(input int i, input nifm_code_t c, input logic v);
        net_code_o[i] = c;
        network_input_bit_o[i] = v;
    endtask
    initial begin
        network_input_bit_o = 16'h0000;
        for (int i = 0; i < 16; i++) net_code_o[i] = 7'h00;
    end
endmodule // nifm_host_model

/* File: bench/network_input_function_map_tb.sv */
// testbench for the network input function map
`timescale 1ns/100ps
module network_input_function_map_tb;
    import nifm_pkg::*;
    logic         clk_i, arst_n_i, intlk, alm, sst, forward, reverse, dsel;
    logic [15:0]  bits, flags;
    nifm_code_t   codes [16];
    logic [127:0] dact, dasg, func;
    int           n_errors = 0;
    int           compares = 0;
    nifm_host_model nifm_host_model_inst (.network_input_bit_o(bits), .net_code_o(codes));
    nifm_top nifm_top_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .network_input_bit_i(bits),
        .net_code_i(codes), .direct_active_i(dact), .direct_assigned_i(dasg), .func_o(func),
        .operator_interlock_o(intlk), .alarm_clear_input_o(alm),
        .sequential_start_input_o(sst), .forward_run_input_o(forward),
        .reverse_run_input_o(reverse), .data_select_bit_0_o(dsel), .general_host_flag_o(flags));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic settle;
        repeat (4) @(negedge clk_i);
    endtask
    task automatic put(input int i, input nifm_code_t c, input logic v);
        nifm_host_model_inst.set_bit(i, c, v);
    endtask
    task automatic complete_run;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_flags;
        for (int i = 0; i < 16; i++) put(i, 7'h20 + 7'(i), 1'(16'ha5c3 >> i));
        settle;
        chk("func", {80'h0, 16'ha5c3, 32'h0800_0000}, func);
        for (int i = 0; i < 16; i++) put(i, 7'h20 + 7'(i), 1'(16'h5a3c >> i));
        settle;
        chk("flags", 128'(16'h5a3c), 128'(flags));
        $display("test flags done");
    endtask
    task automatic t_or;
        for (int i = 0; i < 16; i++) put(i, 7'h00, 1'b1);
        put(3, 7'h01, 1'b1);
        put(9, 7'h01, 1'b0);
        put(7, 7'h05, 1'b1);
        put(8, 7'h30, 1'b1);
        settle;
        chk("func", 128'h0001_0000_0800_0022, func);
        put(3, 7'h01, 1'b0);
        settle;
        chk("forward", 128'h0, 128'(forward));
        put(9, 7'h01, 1'b1);
        settle;
        chk("forward", 128'h1, 128'(forward));
        chk("sst_dsel", 128'h3, 128'({sst, dsel}));
        $display("test or done");
    endtask
    task automatic t_and;
        dasg[2] = 1'b1;
        dasg[24] = 1'b1;
        dact[24] = 1'b1;
        put(4, 7'h02, 1'b1);
        put(6, 7'h1b, 1'b0);
        settle;
        chk("reverse_alm_intlk", 128'h2, 128'({reverse, alm, intlk}));
        dact[2] = 1'b1;
        put(6, 7'h1b, 1'b1);
        settle;
        chk("reverse_intlk", 128'h3, 128'({reverse, intlk}));
        put(4, 7'h02, 1'b0);
        settle;
        chk("reverse", 128'h0, 128'(reverse));
        $display("test and done");
    endtask
    task automatic t_lat;
        put(7, 7'h00, 1'b0);
        put(3, 7'h05, 1'b0);
        put(0, 7'h01, 1'b1);
        dasg[1] = 1'b1;
        dasg[47] = 1'b1;
        dact[47] = 1'b1;
        settle;
        chk("forward", 128'h0, 128'(forward));
        chk("flags", 128'h8000, 128'(flags));
        dact[1] = 1'b1;
        settle;
        chk("forward", 128'h1, 128'(forward));
        put(3, 7'h05, 1'b1);
        repeat (2) @(negedge clk_i);
        chk("sst", 128'h0, 128'(sst));
        @(negedge clk_i);
        chk("sst", 128'h1, 128'(sst));
        $display("test latency done");
    endtask
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        arst_n_i = 1'b0;
        dact = '0;
        dasg = '0;
        repeat (16) @(negedge clk_i);
        arst_n_i = 1'b1;
        settle;
        chk("func", 128'h0800_0000, func);
        $display("test reset done");
        t_flags;
        t_or;
        t_and;
        t_lat;
        complete_run;
    end
endmodule // network_input_function_map_tb
